// ===== hdl/fsc_cmd_core.sv
// Purpose: control-command decoder and seek engine of a floppy controller
// Assumes: host writes bytes only while rqm_o high and dio_o low
// Notes: seek and recalibrate run in the background after the command
`timescale 1ns/10ps
`default_nettype none
module fsc_cmd_core #(
   parameter int unsigned STEP_UNIT_CYC = fsc_pkg::STEP_UNIT_CYC,
   parameter int unsigned LOAD_UNIT_CYC = fsc_pkg::LOAD_UNIT_CYC,
   parameter int unsigned UNLOAD_UNIT_CYC = fsc_pkg::UNLOAD_UNIT_CYC
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic cmd_wr_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic res_rd_i,
   input wire logic xfer_req_i,
   input wire logic track_zero_sense_n_i,
   input wire logic drv_ready_i,
   input wire logic drv_wprot_i,
   input wire logic drv_fault_i,
   input wire logic drv_two_side_i,
   output logic [7:0] rd_data_o,
   output logic rqm_o,
   output logic dio_o,
   output logic busy_o,
   output logic irq_o,
   output logic step_o,
   output logic dir_o,
   output logic head_load_o,
   output logic head_select_o,
   output logic [1:0] drive_select_o
);
   localparam int W = fsc_pkg::TMR_W;

   // ****************************
   // parameter checks
   // ****************************
   if (STEP_UNIT_CYC < 1 || LOAD_UNIT_CYC < 1 || UNLOAD_UNIT_CYC < 1 ||
       longint'(STEP_UNIT_CYC) * 16 >= (longint'(1) << W) ||
       longint'(LOAD_UNIT_CYC) * 128 >= (longint'(1) << W) ||
       longint'(UNLOAD_UNIT_CYC) * 16 >= (longint'(1) << W)) begin : g_bad_param
      $error("fsc_cmd_core: unit cycle count out of range");
   end

   typedef enum logic [1:0] {HS_CMD, HS_ARG, HS_RES} fsc_host_st_t;
   typedef enum logic [2:0] {E_IDLE, E_LOAD, E_PULSE, E_GAP, E_UNLOAD} fsc_eng_st_t;

   function automatic logic [7:0] status_zero(input logic [1:0] code, input logic seek_end, input logic equip,
                                              input logic hd, input logic [1:0] ds);
      logic [7:0] b;
      b = 8'h00;
      b[fsc_pkg::SZ_CODE_LO +: 2] = code;
      b[fsc_pkg::SZ_SEEK_END] = seek_end;
      b[fsc_pkg::SZ_EQUIP] = equip;
      b[fsc_pkg::SZ_HEAD] = hd;
      b[1:0] = ds;
      return b;
   endfunction : status_zero

   function automatic logic cmd_known(input logic [7:0] op);
      return op == fsc_pkg::OP_SPECIFY || op == fsc_pkg::OP_SENSE_DRV || op == fsc_pkg::OP_RECAL ||
             op == fsc_pkg::OP_SENSE_INT || op == fsc_pkg::OP_SEEK;
   endfunction : cmd_known

   function automatic logic [W-1:0] units_to_cyc(input logic [7:0] units, input int unsigned unit);
      return W'(longint'(units) * longint'(unit));
   endfunction : units_to_cyc

   // ****************************
   // pin synchronisers
   // ****************************
   logic [4:0] pin_meta_q;
   logic [4:0] pin_sync_q;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_meta_q <= 5'h01;
         pin_sync_q <= 5'h01;
      end else if (ce_i) begin
         pin_meta_q <= {drv_two_side_i, drv_fault_i, drv_wprot_i, drv_ready_i, track_zero_sense_n_i};
         pin_sync_q <= pin_meta_q;
      end
   end

   logic trk0;
   assign trk0 = !pin_sync_q[0];

   // ****************************
   // host command sequencer
   // ****************************
   fsc_host_st_t hs_q, hs_d;
   logic [7:0] op_q;
   logic arg_idx_q;
   logic rqm_q, dio_q, busy_q;
   logic accept, pop, last_arg, new_sense_int, new_invalid, eng_start;

   assign accept = ce_i && cmd_wr_i && rqm_q && !dio_q;
   assign pop = ce_i && res_rd_i && hs_q == HS_RES;
   assign last_arg = (op_q == fsc_pkg::OP_SPECIFY || op_q == fsc_pkg::OP_SEEK) ? arg_idx_q : 1'b1;
   assign new_sense_int = accept && hs_q == HS_CMD && cmd_data_i == fsc_pkg::OP_SENSE_INT;
   assign new_invalid = accept && hs_q == HS_CMD && !cmd_known(cmd_data_i);

   always_comb begin
      hs_d = hs_q;
      unique case (hs_q)
         HS_CMD: begin
            if (accept) begin
               hs_d = (cmd_data_i == fsc_pkg::OP_SENSE_INT || !cmd_known(cmd_data_i)) ? HS_RES : HS_ARG; // [R3] [R6]
            end
         end
         HS_ARG: begin
            if (accept && last_arg) begin
               hs_d = (op_q == fsc_pkg::OP_SENSE_DRV) ? HS_RES : HS_CMD; // [R4] [R5] [R13]
            end
         end
         HS_RES: begin
            if (pop) begin
               hs_d = HS_CMD; // [R9]
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hs_q <= HS_CMD;
         op_q <= 8'h00;
         arg_idx_q <= 1'b0;
      end else if (ce_i) begin
         hs_q <= hs_d;
         if (accept) begin
            arg_idx_q <= hs_q == HS_ARG;
            if (hs_q == HS_CMD) begin
               op_q <= cmd_data_i;
            end
         end
      end
   end

   // main status: byte accepted drops rqm for one cycle
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rqm_q <= 1'b1;
         dio_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (ce_i) begin
         rqm_q <= !(accept || pop);
         dio_q <= hs_d == HS_RES; // [R7]
         busy_q <= hs_d != HS_CMD; // [R13]
      end
   end

   // ****************************
   // timing setup and drive select
   // ****************************
   logic [3:0] step_int_q, unload_q;
   logic [6:0] load_q;
   logic hd_q;
   logic [1:0] ds_q;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         step_int_q <= 4'h0;
         unload_q <= 4'h0;
         load_q <= 7'h00;
      end else if (ce_i && accept && hs_q == HS_ARG && op_q == fsc_pkg::OP_SPECIFY) begin
         if (!arg_idx_q) begin
            step_int_q <= cmd_data_i[7:4]; // [R5]
            unload_q <= cmd_data_i[3:0];
         end else begin
            load_q <= cmd_data_i[7:1]; // [R14]
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hd_q <= 1'b0;
         ds_q <= 2'h0;
      end else if (ce_i && accept && hs_q == HS_ARG && !arg_idx_q && op_q != fsc_pkg::OP_SPECIFY) begin
         hd_q <= cmd_data_i[2]; // [R4]
         ds_q <= cmd_data_i[1:0];
      end
   end

   // ****************************
   // result byte and interrupt
   // ****************************
   logic [7:0] rd_q, int_sz_q, eng_sz_q;
   logic int_pend_q, poll_pend_q, poll_arm_q, irq_q, eng_done_q;
   logic [7:0] drv_st;

   always_comb begin
      drv_st = 8'h00;
      drv_st[fsc_pkg::DRV_FAULT] = pin_sync_q[3];
      drv_st[fsc_pkg::DRV_WPROT] = pin_sync_q[2];
      drv_st[fsc_pkg::DRV_READY] = pin_sync_q[1];
      drv_st[fsc_pkg::DRV_TRK0] = trk0;
      drv_st[fsc_pkg::DRV_TWO_SIDE] = pin_sync_q[4];
      drv_st[fsc_pkg::DRV_HEAD] = cmd_data_i[2];
      drv_st[1:0] = cmd_data_i[1:0];
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_q <= 8'h00;
      end else if (ce_i && accept) begin
         if (new_sense_int) begin
            rd_q <= int_pend_q ? int_sz_q :
                    poll_pend_q ? status_zero(fsc_pkg::CODE_POLL, 1'b0, 1'b0, 1'b0, 2'h0) :
                    fsc_pkg::INVALID_RESULT; // [R1] [R2]
         end else if (new_invalid) begin
            rd_q <= status_zero(fsc_pkg::CODE_INVALID, 1'b0, 1'b0, 1'b0, 2'h0); // [R8]
         end else if (hs_q == HS_ARG && op_q == fsc_pkg::OP_SENSE_DRV) begin
            rd_q <= drv_st; // [R4]
         end
      end
   end

   // event set wins over the query's clear
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         int_pend_q <= 1'b0;
         int_sz_q <= 8'h00;
         poll_pend_q <= 1'b1;
         poll_arm_q <= 1'b1;
         irq_q <= 1'b0;
      end else if (ce_i) begin
         poll_arm_q <= 1'b0;
         if (new_sense_int) begin
            poll_pend_q <= 1'b0;
         end
         if (eng_done_q) begin
            int_pend_q <= 1'b1;
            int_sz_q <= eng_sz_q;
         end else if (new_sense_int) begin
            int_pend_q <= 1'b0;
         end
         if (eng_done_q || xfer_req_i || poll_arm_q) begin
            irq_q <= 1'b1; // [R10] [R13]
         end else if (new_sense_int) begin
            irq_q <= 1'b0; // [R1]
         end
      end
   end

   // ****************************
   // seek and recalibrate engine
   // ****************************
   fsc_eng_st_t eng_q;
   logic [7:0] cur_cyl_q, tgt_cyl_q;
   logic [6:0] steps_q;
   logic recal_q, step_q, dir_q, head_q, eng_hd_q, tmr_load_q, tmr_done;
   logic [1:0] eng_ds_q;
   logic [W-1:0] tmr_cnt_q;
   logic at_target, give_up;

   assign eng_start = accept && hs_q == HS_ARG && last_arg &&
                      (op_q == fsc_pkg::OP_RECAL || op_q == fsc_pkg::OP_SEEK) &&
                      (eng_q == E_IDLE || eng_q == E_UNLOAD);
   assign at_target = recal_q ? trk0 : cur_cyl_q == tgt_cyl_q;
   assign give_up = recal_q && steps_q == fsc_pkg::RECAL_MAX_STEPS;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         eng_q <= E_IDLE;
         cur_cyl_q <= 8'h00;
         tgt_cyl_q <= 8'h00;
         steps_q <= 7'h00;
         recal_q <= 1'b0;
         step_q <= 1'b0;
         dir_q <= 1'b0;
         head_q <= 1'b0;
         eng_hd_q <= 1'b0;
         eng_ds_q <= 2'h0;
         eng_done_q <= 1'b0;
         eng_sz_q <= 8'h00;
         tmr_load_q <= 1'b0;
         tmr_cnt_q <= '0;
      end else if (ce_i) begin
         tmr_load_q <= 1'b0;
         eng_done_q <= 1'b0;
         if (eng_start) begin
            recal_q <= op_q == fsc_pkg::OP_RECAL;
            tgt_cyl_q <= op_q == fsc_pkg::OP_RECAL ? 8'h00 : cmd_data_i;
            // direction settles at least three cycles before the first step edge, only one if the unload delay ends in the start cycle
            dir_q <= op_q != fsc_pkg::OP_RECAL && cur_cyl_q < cmd_data_i;
            eng_hd_q <= op_q == fsc_pkg::OP_RECAL ? 1'b0 : hd_q;
            eng_ds_q <= op_q == fsc_pkg::OP_RECAL ? cmd_data_i[1:0] : ds_q;
            steps_q <= 7'h00;
            head_q <= 1'b1;
            tmr_load_q <= 1'b1;
            tmr_cnt_q <= head_q ? W'(1) : units_to_cyc({load_q == 7'h00, load_q}, LOAD_UNIT_CYC); // [R15]
            eng_q <= E_LOAD;
         end else begin
            unique case (eng_q)
               E_IDLE: begin
               end
               E_LOAD, E_GAP: begin
                  if (tmr_done) begin
                     tmr_load_q <= 1'b1;
                     if (at_target || give_up) begin
                        eng_done_q <= 1'b1;
                        eng_sz_q <= status_zero(at_target ? fsc_pkg::CODE_NORMAL : fsc_pkg::CODE_ABNORMAL,
                                                1'b1, !at_target, eng_hd_q, eng_ds_q); // [R12] [R13]
                        if (recal_q && at_target) begin
                           cur_cyl_q <= 8'h00;
                        end
                        tmr_cnt_q <= units_to_cyc({3'h0, unload_q == 4'h0, unload_q}, UNLOAD_UNIT_CYC); // [R15]
                        eng_q <= E_UNLOAD;
                     end else begin
                        step_q <= 1'b1;
                        tmr_cnt_q <= W'(fsc_pkg::STEP_PULSE_CYC);
                        eng_q <= E_PULSE;
                     end
                  end
               end
               E_PULSE: begin
                  if (tmr_done) begin
                     step_q <= 1'b0;
                     cur_cyl_q <= dir_q ? cur_cyl_q + 8'h01 : cur_cyl_q - 8'h01;
                     steps_q <= steps_q + 7'h01;
                     tmr_load_q <= 1'b1;
                     tmr_cnt_q <= units_to_cyc({3'h0, fsc_pkg::STEP_UNITS_TOP - {1'b0, step_int_q}},
                                               STEP_UNIT_CYC); // [R15]
                     eng_q <= E_GAP;
                  end
               end
               E_UNLOAD: begin
                  if (tmr_done) begin
                     head_q <= 1'b0;
                     eng_q <= E_IDLE;
                  end
               end
            endcase
         end
      end
   end

   fsc_delay_timer #(.W(W)) u_timer (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .load_i(tmr_load_q),
      .count_i(tmr_cnt_q),
      .done_o(tmr_done)
   );

   assign rd_data_o = rd_q;
   assign rqm_o = rqm_q;
   assign dio_o = dio_q;
   assign busy_o = busy_q;
   assign irq_o = irq_q;
   assign step_o = step_q;
   assign dir_o = dir_q;
   assign head_load_o = head_q;
   assign head_select_o = hd_q;
   assign drive_select_o = ds_q;

   // ****************************
   // checks
   // ****************************
   chk_sense_irq_clear: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R1]
      new_sense_int && !eng_done_q && !xfer_req_i && !poll_arm_q |=> !irq_o && dio_o)
      else $error("interrupt query did not clear interrupt");
   chk_poll_code: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R2]
      new_sense_int && !int_pend_q && poll_pend_q |=> rd_data_o == 8'hC0)
      else $error("polling cause not reported");
   chk_drive_status: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R4]
      accept && hs_q == HS_ARG && op_q == fsc_pkg::OP_SENSE_DRV
      |=> rd_data_o[2:0] == $past(cmd_data_i[2:0]) && dio_o)
      else $error("drive status byte wrong");
   chk_specify_load: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R5]
      accept && hs_q == HS_ARG && op_q == fsc_pkg::OP_SPECIFY && !arg_idx_q
      |=> step_int_q == $past(cmd_data_i[7:4]) && unload_q == $past(cmd_data_i[3:0]) && !dio_o)
      else $error("timing setup not loaded");
   chk_invalid_noirq: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R6]
      new_invalid && !irq_o && !eng_done_q && !xfer_req_i && !poll_arm_q |=> !irq_o)
      else $error("undefined opcode raised interrupt");
   chk_invalid_msr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R7]
      new_invalid && ce_i |=> !rqm_o ##1 (rqm_o && dio_o && rd_data_o == fsc_pkg::INVALID_RESULT))
      else $error("undefined opcode status or byte wrong");
   chk_recal_limit: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R12]
      eng_done_q && eng_sz_q[fsc_pkg::SZ_EQUIP] |-> recal_q && steps_q == 7'h4D)
      else $error("recalibrate ended abnormally early");
   chk_seek_end: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R13]
      eng_done_q && !recal_q |-> cur_cyl_q == tgt_cyl_q && eng_sz_q[fsc_pkg::SZ_SEEK_END])
      else $error("seek ended off target");
   chk_step_head: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R15]
      $rose(step_o) |-> head_load_o && $past(tmr_done))
      else $error("step without loaded head or delay");
endmodule : fsc_cmd_core
`default_nettype wire

// ===== hdl/fsc_pkg.sv
// Purpose: constants for the floppy control-command decoder
// Assumes: 200 MHz core clock, one drive engine shared by all drives
// Notes: times are kept in their own unit and turned into cycles here
// How it works
// R1 - interrupt query clears interrupt, returns status zero
// R2 - status zero carries seek-end and completion cause
// R3 - query opcode is lone D3, straight to result
// R4 - drive query takes select byte, returns drive status
// R5 - timing setup loads step and unload nibbles
// R6 - undefined opcode ends at once, no interrupt
// R7 - undefined opcode sets direction and request bits
// R8 - undefined opcode result byte reads eighty hex
// R9 - undefined opcode returns to idle, drives untouched
// R10 - non-dma byte transfer need raises interrupt
// R11 - host queries interrupt after every seek/recalibrate
// R12 - recalibrate gives up abnormally after 77 steps
// R13 - seek ends at target; busy drops after command
// R14 - timing setup third byte loads head load delay
// R15 - step spacing and head delays are honoured
package fsc_pkg;
   localparam logic [7:0] OP_SPECIFY = 8'h03;
   localparam logic [7:0] OP_SENSE_DRV = 8'h04;
   localparam logic [7:0] OP_RECAL = 8'h07;
   localparam logic [7:0] OP_SENSE_INT = 8'h08;
   localparam logic [7:0] OP_SEEK = 8'h0F;
   localparam logic [7:0] INVALID_RESULT = 8'h80;
   // status byte zero fields
   localparam int SZ_CODE_LO = 6;
   localparam int SZ_SEEK_END = 5;
   localparam int SZ_EQUIP = 4;
   localparam int SZ_HEAD = 2;
   localparam logic [1:0] CODE_NORMAL = 2'h0;
   localparam logic [1:0] CODE_ABNORMAL = 2'h1;
   localparam logic [1:0] CODE_INVALID = 2'h2;
   localparam logic [1:0] CODE_POLL = 2'h3;
   // drive status byte fields
   localparam int DRV_FAULT = 7;
   localparam int DRV_WPROT = 6;
   localparam int DRV_READY = 5;
   localparam int DRV_TRK0 = 4;
   localparam int DRV_TWO_SIDE = 3;
   localparam int DRV_HEAD = 2;
   localparam logic [6:0] RECAL_MAX_STEPS = 7'h4D;
   localparam logic [4:0] STEP_UNITS_TOP = 5'h10;
   localparam int TMR_W = 26;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned STEP_UNIT_NS = 1000000;
   localparam int unsigned LOAD_UNIT_NS = 1000000;
   localparam int unsigned UNLOAD_UNIT_NS = 1000000;
   localparam int unsigned STEP_PULSE_NS = 1000;
   localparam int unsigned STEP_UNIT_CYC = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOAD_UNIT_CYC = (LOAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned UNLOAD_UNIT_CYC = (UNLOAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : fsc_pkg

// ===== hdl/fsc_delay_timer.sv
// Purpose: one-shot down counter for step and head delays
// Assumes: count_i is at least one when load_i is high
// Notes: a new load overrides a running count
`timescale 1ns/10ps
`default_nettype none
module fsc_delay_timer #(
   parameter int W = fsc_pkg::TMR_W
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   output logic done_o
);
   logic [W-1:0] cnt_q;
   logic done_q;

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (ce_i) begin
         done_q <= 1'b0;
         if (load_i) begin
            cnt_q <= count_i;
         end else if (cnt_q == W'(1)) begin
            cnt_q <= '0;
            done_q <= 1'b1;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
         end
      end
   end

   assign done_o = done_q;
endmodule : fsc_delay_timer
`default_nettype wire

// ===== verif/fsc_drive_model.sv
// Purpose: disk drive model that follows the step pulses
// Assumes: head sits on cylinder 0 after reset
// Notes: stuck_i hides track zero so a recalibrate runs out of steps
`timescale 1ns/10ps
`default_nettype none
module fsc_drive_model (
   input wire logic nrst_i,
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic stuck_i,
   output logic track_zero_sense_n_o
);
   logic [7:0] cyl_q;
   always_ff @(posedge step_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cyl_q <= 8'h00;
      end else if (dir_i) begin
         cyl_q <= cyl_q + 8'h01;
      end else if (cyl_q != 8'h00) begin
         cyl_q <= cyl_q - 8'h01;
      end
   end
   assign track_zero_sense_n_o = stuck_i || (cyl_q != 8'h00);
endmodule : fsc_drive_model
`default_nettype wire

// ===== verif/floppy_ctrl_sense_specify_cmds_tb.sv
// Purpose: self-checking bench of the control-command decoder
// Assumes: delay units shortened to 4 cycles
// Notes: host side driven by tasks, track zero by fsc_drive_model, drive status pins from the pins vector
`timescale 1ns/10ps
`default_nettype none
module floppy_ctrl_sense_specify_cmds_tb;
   logic ref_clk_i, nrst_i, cmd_wr_i, res_rd_i, xfer_req_i, stuck, hd, tz_n, ce;
   logic rqm_o, dio_o, busy_o, irq_o, step_o, dir_o, head_load_o, head_select_o;
   logic [7:0] cmd_data_i, rd_data_o, res, b;
   logic [3:0] pins, step_iv;
   logic [1:0] drive_select_o, ds;
   int err_count, check_count, steps, n, seed, gap_ns, gap_bad;
   time t_last;
   fsc_cmd_core #(.STEP_UNIT_CYC(4), .LOAD_UNIT_CYC(4), .UNLOAD_UNIT_CYC(4)) i_dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce), .cmd_wr_i(cmd_wr_i),
      .cmd_data_i(cmd_data_i), .res_rd_i(res_rd_i), .xfer_req_i(xfer_req_i),
      .track_zero_sense_n_i(tz_n), .drv_ready_i(pins[1]), .drv_wprot_i(pins[2]),
      .drv_fault_i(pins[3]), .drv_two_side_i(pins[0]), .rd_data_o(rd_data_o), .rqm_o(rqm_o),
      .dio_o(dio_o), .busy_o(busy_o), .irq_o(irq_o), .step_o(step_o), .dir_o(dir_o),
      .head_load_o(head_load_o), .head_select_o(head_select_o), .drive_select_o(drive_select_o));
   fsc_drive_model i_drive (.nrst_i(nrst_i), .step_i(step_o), .dir_i(dir_o), .stuck_i(stuck),
      .track_zero_sense_n_o(tz_n));
   // ***************************************
   // host tasks
   // ***************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic tick();
      @(posedge ref_clk_i);
      #1;
   endtask : tick
   task automatic wait_rdy(input logic want_dio);
      int i;
      i = 0;
      while (!(rqm_o === 1'b1 && dio_o === want_dio) && i < 1000) begin
         tick();
         i++;
      end
      chk("host ready", 8'h00, {7'h00, i >= 1000});
   endtask : wait_rdy
   task automatic wr(input logic [7:0] v);
      wait_rdy(1'b0);
      cmd_wr_i = 1'b1;
      cmd_data_i = v;
      tick();
      cmd_wr_i = 1'b0;
      cmd_data_i = ~v;
   endtask : wr
   task automatic rd(output logic [7:0] v);
      wait_rdy(1'b1);
      v = rd_data_o;
      res_rd_i = 1'b1;
      tick();
      res_rd_i = 1'b0;
   endtask : rd
   task automatic sense(input logic [7:0] exp);
      wr(8'h08);
      chk("query dio", 8'h01, {7'h00, dio_o});
      rd(res);
      chk("status zero", exp, res);
      chk("irq cleared", 8'h00, {7'h00, irq_o});
   endtask : sense
   task automatic wait_irq();
      int i;
      i = 0;
      while (irq_o !== 1'b1 && i < 40000) begin
         tick();
         i++;
      end
      chk("irq raised", 8'h01, {7'h00, irq_o});
   endtask : wait_irq
   task automatic results();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   // ***************************************
   // clock, step watch, watchdog
   // ***************************************
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end
   // low time of step must match the programmed interval within two cycles
   always @(posedge step_o) begin
      if (steps > 0 && (($time - t_last) < gap_ns || ($time - t_last) > gap_ns + 10)) gap_bad = 1;
      steps++;
   end
   always @(negedge step_o) begin
      t_last = $time;
   end
   initial begin
      #450000;
      err_count++;
      results();
   end
   // ***************************************
   // tests
   // ***************************************
   initial begin
      nrst_i = 1'b0;
      ce = 1'b1;
      cmd_wr_i = 1'b0;
      res_rd_i = 1'b0;
      xfer_req_i = 1'b0;
      cmd_data_i = 8'h00;
      stuck = 1'b0;
      pins = 4'h0;
      err_count = 0;
      check_count = 0;
      steps = 0;
      gap_ns = 0;
      gap_bad = 0;
      seed = $urandom(72280);
      repeat (3) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      tick();
      chk("poll irq", 8'h01, {7'h00, irq_o});
      sense(8'hC0);
      sense(8'h80);
      for (int k = 0; k < 6; k++) begin
         b = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom_range(255));
         if (b inside {8'h03, 8'h04, 8'h07, 8'h08, 8'h0F}) b = 8'h90;
         wr(b);
         chk("undef dio", 8'h01, {7'h00, dio_o});
         tick();
         chk("undef rqm", 8'h01, {7'h00, rqm_o});
         chk("undef irq", 8'h00, {7'h00, irq_o});
         rd(res);
         chk("undef result", 8'h80, res);
         chk("undef idle", 8'h00, {6'h00, busy_o, head_load_o});
      end
      pins = 4'($urandom);
      hd = 1'($urandom);
      ds = 2'($urandom);
      repeat (4) tick();
      wr(8'h04);
      wr({5'h00, hd, ds});
      rd(res);
      chk("drive status", {pins[3], pins[2], pins[1], 1'b1, pins[0], hd, ds}, res);
      xfer_req_i = 1'b1;
      tick();
      xfer_req_i = 1'b0;
      tick();
      chk("xfer irq", 8'h01, {7'h00, irq_o});
      wr(8'h08);
      rd(res);
      chk("xfer irq cleared", 8'h00, {7'h00, irq_o});
      tick();
      ce = 1'b0;
      cmd_wr_i = 1'b1;
      cmd_data_i = 8'h08;
      xfer_req_i = 1'b1;
      repeat (3) tick();
      ce = 1'b1;
      cmd_wr_i = 1'b0;
      xfer_req_i = 1'b0;
      tick();
      chk("frozen rqm dio irq", 8'h04, {5'h00, rqm_o, dio_o, irq_o});
      step_iv = 4'h8 | 4'($urandom);
      gap_ns = (16 - step_iv) * 4 * 5;
      wr(8'h03);
      wr({step_iv, 4'($urandom)});
      wr(8'h04);
      tick();
      chk("setup no result", 8'h00, {6'h00, dio_o, busy_o});
      n = 1 + $urandom_range(19);
      steps = 0;
      wr(8'h0F);
      wr({5'h00, hd, ds});
      wr(8'(n));
      tick();
      chk("seek not busy", 8'h00, {7'h00, busy_o});
      chk("seek select", {5'h00, hd, ds}, {5'h00, head_select_o, drive_select_o});
      wait_irq();
      chk("seek steps", 8'(n), 8'(steps));
      chk("seek dir", 8'h01, {7'h00, dir_o});
      sense({5'h04, hd, ds});
      steps = 0;
      wr(8'h07);
      wr({6'h00, ds});
      wait_irq();
      chk("recal steps", 8'(n), 8'(steps));
      sense({6'h08, ds});
      stuck = 1'b1;
      steps = 0;
      wr(8'h07);
      wr({6'h00, ds});
      wait_irq();
      chk("recal give up", 8'h4D, 8'(steps));
      sense({6'h1C, ds});
      chk("step spacing", 8'h00, 8'(gap_bad));
      results();
   end
endmodule : floppy_ctrl_sense_specify_cmds_tb
`default_nettype wire
